// ==== src/inductive_channel_config_regs.sv ====
// Top: serial target port and the channel setup / fast tracking register bank.
module inductive_channel_config_regs
	import inductive_cfg_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial bus pins (data line is open drain)
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output wire logic        sdaOut,
	output wire logic        sdaOe,
	// channel 2 sensor setup
	output wire logic        resRangeCh2,
	output wire logic [1:0]  oscBandCh2,
	output wire logic [4:0]  cycleCountCh2,
	// channel 3 sensor setup
	output wire logic        resRangeCh3,
	output wire logic [1:0]  oscBandCh3,
	output wire logic [4:0]  cycleCountCh3,
	// baseline tracker factors
	output wire logic [1:0]  trackFactorCh0,
	output wire logic [1:0]  trackFactorCh1,
	output wire logic [1:0]  trackFactorCh2,
	output wire logic [1:0]  trackFactorCh3
);

	// ------------------------------------------------------------------
	// pin filtering and bus events
	// ------------------------------------------------------------------
	line_sync_if sclLine();
	line_sync_if sdaLine();

	assign sclLine.raw = sclIn;
	assign sdaLine.raw = sdaIn;

	pin_filter u_scl_filter (
		.clk   (clk),
		.rst_n (rst_n),
		.line  (sclLine.filt)
	);

	pin_filter u_sda_filter (
		.clk   (clk),
		.rst_n (rst_n),
		.line  (sdaLine.filt)
	);

	logic sclLvl;
	logic sdaLvl;
	logic sclPrev_ff;
	logic sdaPrev_ff;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclLvl = sclLine.level;
	assign sdaLvl = sdaLine.level;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclPrev_ff <= 1'h1;
			sdaPrev_ff <= 1'h1;
		end else begin
			sclPrev_ff <= sclLvl;
			sdaPrev_ff <= sdaLvl;
		end
	end

	assign sclRise   = sclLvl & ~sclPrev_ff;
	assign sclFall   = ~sclLvl & sclPrev_ff;
	assign startCond = sclLvl & sclPrev_ff & sdaPrev_ff & ~sdaLvl;
	assign stopCond  = sclLvl & sclPrev_ff & ~sdaPrev_ff & sdaLvl;

	// ------------------------------------------------------------------
	// register storage and decode
	// ------------------------------------------------------------------
	logic [7:0] sensorCh2Setup_ff;
	logic [7:0] fastTrackCh0_ff;
	logic [7:0] sensorCh3Setup_ff;
	logic [7:0] fastTrackCh1Ch2_ff;
	logic [7:0] fastTrackCh3_ff;
	logic [7:0] rx_ff;
	logic [7:0] ptr_ff;
	logic [3:0] bitCnt_ff;
	serial_state_type state_ff;

	logic       hitCh2Setup;
	logic       hitTrackCh0;
	logic       hitCh3Setup;
	logic       hitTrackCh12;
	logic       hitTrackCh3;
	logic       regWrite;
	logic       byteDone;
	logic [7:0] rdData;

	assign hitCh2Setup  = (ptr_ff == OFF_SENSOR_CH2_SETUP);
	assign hitTrackCh0  = (ptr_ff == OFF_FAST_TRACK_CH0);
	assign hitCh3Setup  = (ptr_ff == OFF_SENSOR_CH3_SETUP);
	assign hitTrackCh12 = (ptr_ff == OFF_FAST_TRACK_CH1_CH2);
	assign hitTrackCh3  = (ptr_ff == OFF_FAST_TRACK_CH3);
	assign byteDone     = (bitCnt_ff == BITS_PER_BYTE);
	assign regWrite     = (state_ff == ST_WDATA) & sclFall & byteDone;

	// unmapped offsets read zero and swallow writes, yet are still acked
	assign rdData = hitCh2Setup  ? sensorCh2Setup_ff :
	                hitTrackCh0  ? fastTrackCh0_ff :
	                hitCh3Setup  ? sensorCh3Setup_ff :
	                hitTrackCh12 ? fastTrackCh1Ch2_ff :
	                hitTrackCh3  ? fastTrackCh3_ff : RD_UNMAPPED;

	// reserved bits are stored as written, the host keeps them at reset value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sensorCh2Setup_ff  <= RST_SENSOR_SETUP;
			sensorCh3Setup_ff  <= RST_SENSOR_SETUP;
			fastTrackCh0_ff    <= RST_FAST_TRACK_CH0;
			fastTrackCh1Ch2_ff <= RST_FAST_TRACK_CH1_CH2;
			fastTrackCh3_ff    <= RST_FAST_TRACK_CH3;
		end else if (regWrite) begin
			if (hitCh2Setup)  sensorCh2Setup_ff  <= rx_ff;
			if (hitCh3Setup)  sensorCh3Setup_ff  <= rx_ff;
			if (hitTrackCh0)  fastTrackCh0_ff    <= rx_ff;
			if (hitTrackCh12) fastTrackCh1Ch2_ff <= rx_ff;
			if (hitTrackCh3)  fastTrackCh3_ff    <= rx_ff;
		end
	end

	// ------------------------------------------------------------------
	// field outputs
	// ------------------------------------------------------------------
	// band code 3 is passed on unchanged; its effect is left to the sensor
	assign resRangeCh2    = sensorCh2Setup_ff[RES_RANGE_BIT];
	assign oscBandCh2     = sensorCh2Setup_ff[OSC_BAND_HI:OSC_BAND_LO];
	assign cycleCountCh2  = sensorCh2Setup_ff[CYCLE_HI:CYCLE_LO];
	assign resRangeCh3    = sensorCh3Setup_ff[RES_RANGE_BIT];
	assign oscBandCh3     = sensorCh3Setup_ff[OSC_BAND_HI:OSC_BAND_LO];
	assign cycleCountCh3  = sensorCh3Setup_ff[CYCLE_HI:CYCLE_LO];
	assign trackFactorCh0 = fastTrackCh0_ff[TF_CH0_HI:TF_CH0_LO];
	assign trackFactorCh1 = fastTrackCh1Ch2_ff[TF_CH1_HI:TF_CH1_LO];
	assign trackFactorCh2 = fastTrackCh1Ch2_ff[TF_CH2_HI:TF_CH2_LO];
	assign trackFactorCh3 = fastTrackCh3_ff[TF_CH3_HI:TF_CH3_LO];

	// ------------------------------------------------------------------
	// serial target state machine
	// ------------------------------------------------------------------
	logic [7:0] tx_ff;
	logic       rw_ff;
	logic       masterAck_ff;
	logic       sdaLow_ff;
	logic       addrMatch;

	serial_state_type nxt_state;
	logic [3:0]       nxt_bitCnt;
	logic [7:0]       nxt_ptr;
	logic [7:0]       nxt_tx;
	logic             nxt_rw;
	logic             nxt_sdaLow;

	assign addrMatch = (rx_ff[7:1] == DEV_ADDR);

	always_comb begin
		nxt_state  = state_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_ptr    = ptr_ff;
		nxt_tx     = tx_ff;
		nxt_rw     = rw_ff;
		nxt_sdaLow = sdaLow_ff;
		if (stopCond) begin
			nxt_state  = ST_IDLE;
			nxt_sdaLow = 1'h0;
		end else if (startCond) begin
			// repeated start keeps the pointer for a following read
			nxt_state  = ST_ADDR;
			nxt_bitCnt = 4'h0;
			nxt_sdaLow = 1'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					nxt_bitCnt = 4'h0;
				end
				ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA: begin
					if (sclRise) begin
						nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
					end
					if (sclFall && byteDone) begin
						nxt_bitCnt = 4'h0;
						case (state_ff)
							ST_ADDR: begin
								nxt_state  = addrMatch ? ST_ADDR_ACK : ST_IDLE;
								nxt_sdaLow = addrMatch;
								nxt_rw     = rx_ff[0];
							end
							ST_PTR: begin
								nxt_state  = ST_PTR_ACK;
								nxt_sdaLow = 1'h1;
								nxt_ptr    = rx_ff;
							end
							ST_WDATA: begin
								nxt_state  = ST_WDATA_ACK;
								nxt_sdaLow = 1'h1;
								nxt_ptr    = 8'(ptr_ff + PTR_STEP);
							end
							default: begin
								nxt_state  = ST_RDATA_ACK;
								nxt_sdaLow = 1'h0;
								nxt_ptr    = 8'(ptr_ff + PTR_STEP);
							end
						endcase
					end else if (sclFall && (state_ff == ST_RDATA)) begin
						nxt_tx     = {tx_ff[6:0], 1'h0};
						nxt_sdaLow = ~tx_ff[6];
					end
				end
				ST_ADDR_ACK: begin
					if (sclFall) begin
						nxt_state  = rw_ff ? ST_RDATA : ST_PTR;
						nxt_tx     = rdData;
						nxt_sdaLow = rw_ff & ~rdData[7];
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					if (sclFall) begin
						nxt_state  = ST_WDATA;
						nxt_sdaLow = 1'h0;
					end
				end
				ST_RDATA_ACK: begin
					// a master nack ends the read; the target waits for stop or start
					if (sclFall) begin
						nxt_state  = masterAck_ff ? ST_RDATA : ST_IDLE;
						nxt_tx     = rdData;
						nxt_sdaLow = masterAck_ff & ~rdData[7];
					end
				end
				default: begin
					nxt_state  = ST_IDLE;
					nxt_sdaLow = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff  <= ST_IDLE;
			bitCnt_ff <= 4'h0;
			ptr_ff    <= 8'h00;
			tx_ff     <= 8'h00;
			rw_ff     <= 1'h0;
			sdaLow_ff <= 1'h0;
		end else begin
			state_ff  <= nxt_state;
			bitCnt_ff <= nxt_bitCnt;
			ptr_ff    <= nxt_ptr;
			tx_ff     <= nxt_tx;
			rw_ff     <= nxt_rw;
			sdaLow_ff <= nxt_sdaLow;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_ff        <= 8'h00;
			masterAck_ff <= 1'h0;
		end else if (sclRise) begin
			rx_ff        <= {rx_ff[6:0], sdaLvl};
			masterAck_ff <= ~sdaLvl;
		end
	end

	// open drain: only ever pulls low
	assign sdaOut = 1'h0;
	assign sdaOe  = sdaLow_ff;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_res_range_write: assert property (regWrite && hitCh2Setup |=> resRangeCh2 == $past(rx_ff[7]))
		else $error("channel 2 resistance range did not take the written bit");
	a_osc_band_write: assert property (regWrite && hitCh3Setup |=> oscBandCh3 == $past(rx_ff[6:5]))
		else $error("channel 3 band did not take the written field");
	a_cycle_count_write: assert property (regWrite && hitCh2Setup |=> cycleCountCh2 == $past(rx_ff[4:0]))
		else $error("channel 2 cycle count did not take the written field");
	a_track_factor_hold: assert property (!(regWrite && hitTrackCh12) |=> $stable(trackFactorCh1) && $stable(trackFactorCh2))
		else $error("channel 1/2 tracking factor changed without a write");
	a_track_ch0_reset: assert property ($past(!rst_n) |-> fastTrackCh0_ff == 8'hDA && trackFactorCh0 == 2'h1)
		else $error("channel 0 tracking register wrong after reset");
	a_track_ch12_reset: assert property ($past(!rst_n) |-> fastTrackCh1Ch2_ff == 8'h50)
		else $error("channel 1/2 tracking register wrong after reset");
	a_track_ch3_reset: assert property ($past(!rst_n) |-> fastTrackCh3_ff == 8'h01)
		else $error("channel 3 tracking register wrong after reset");
	a_setup_reset: assert property ($past(!rst_n) |-> sensorCh2Setup_ff == 8'h04 && cycleCountCh3 == 5'h04)
		else $error("setup registers wrong after reset");
	a_track_ch3_write: assert property (regWrite && hitTrackCh3 ##1 !regWrite |=> trackFactorCh3 == $past(rx_ff[1:0], 2))
		else $error("channel 3 tracking factor lost a write");

	c_write_setup: cover property (regWrite && hitCh2Setup);
	c_write_track: cover property (regWrite && hitTrackCh0);
	c_read_byte: cover property (state_ff == ST_RDATA_ACK && sclFall && masterAck_ff);
	c_read_nack: cover property (state_ff == ST_RDATA_ACK && sclFall && !masterAck_ff);

endmodule

// ==== src/inductive_cfg_pkg.sv ====
// Package: register map, field layout, reset values and serial states of the channel config bank.
//
// Functional notes
// - Bit 7 picks the resistance range, 0 low (50 ohm-4 kohm), 1 high; resets 0.
// - Bits 6-5 pick oscillation band 1-3.3/3.3-10/10-30 MHz; code 3 reserved; resets 0.
// - Bits 4-0 hold the sensor cycle count, resets 4, sets the sampling window.
// - Each channel has a two-bit fast tracking factor, values 0 to 3.
// - Channel 0 factor at bits 2-1; bits 7-3 reset 1Bh, bit 0 resets 0; DAh.
// - Channel 2 factor bits 7-6, channel 1 bits 5-4; bits 3-0 zero; resets 50h.
// - Channel 3 factor at bits 1-0; bits 7-2 reset zero; register resets 01h.
// - Channel 2 and 3 setup registers reset 04h and are fully read/write.
package inductive_cfg_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_SENSOR_CH2_SETUP   = 8'h24;
	localparam logic [7:0] OFF_FAST_TRACK_CH0     = 8'h25;
	localparam logic [7:0] OFF_SENSOR_CH3_SETUP   = 8'h26;
	localparam logic [7:0] OFF_FAST_TRACK_CH1_CH2 = 8'h28;
	localparam logic [7:0] OFF_FAST_TRACK_CH3     = 8'h2B;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_SENSOR_SETUP       = 8'h04;
	localparam logic [7:0] RST_FAST_TRACK_CH0     = 8'hDA;
	localparam logic [7:0] RST_FAST_TRACK_CH1_CH2 = 8'h50;
	localparam logic [7:0] RST_FAST_TRACK_CH3     = 8'h01;
	localparam logic [7:0] RD_UNMAPPED            = 8'h00;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int RES_RANGE_BIT = 7;
	localparam int OSC_BAND_HI   = 6;
	localparam int OSC_BAND_LO   = 5;
	localparam int CYCLE_HI      = 4;
	localparam int CYCLE_LO      = 0;
	localparam int TF_CH0_HI     = 2;
	localparam int TF_CH0_LO     = 1;
	localparam int TF_CH2_HI     = 7;
	localparam int TF_CH2_LO     = 6;
	localparam int TF_CH1_HI     = 5;
	localparam int TF_CH1_LO     = 4;
	localparam int TF_CH3_HI     = 1;
	localparam int TF_CH3_LO     = 0;

	// ------------------------------------------------------------------
	// serial port
	// ------------------------------------------------------------------
	// target address, arbitrary value
	localparam logic [6:0] DEV_ADDR      = 7'h2A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] PTR_STEP      = 8'h01;

	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_PTR       = 9'h008,
		ST_PTR_ACK   = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RDATA_ACK = 9'h100
	} serial_state_type;

endpackage

// ==== src/line_sync_if.sv ====
// Interface: one raw pin line and its filtered level.
interface line_sync_if;
	logic raw;
	logic level;

	modport filt (input raw, output level);
	modport user (output raw, input level);
endinterface

// ==== src/pin_filter.sv ====
// Pin filter: three-stage synchroniser whose level follows once stages two and three agree.
module pin_filter (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// filtered line
	line_sync_if.filt  line
);

	logic stage1_ff;
	logic stage2_ff;
	logic stage3_ff;
	logic level_ff;
	logic agree;

	// idle bus lines sit high, so reset to one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_ff <= 1'h1;
			stage2_ff <= 1'h1;
			stage3_ff <= 1'h1;
		end else begin
			stage1_ff <= line.raw;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	assign agree = (stage2_ff == stage3_ff);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_ff <= 1'h1;
		end else if (agree) begin
			level_ff <= stage3_ff;
		end
	end

	assign line.level = level_ff;

endmodule

// ==== verif/serial_host_model.sv ====
// Host model: two-wire bus master that drives the clock line and the open-drain data line.
module serial_host_model (
	// clock and device drive
	input  wire logic clk,
	input  wire logic sdaOe,
	// resolved bus lines
	output logic      sclLine,
	output wire logic sdaLine
);
	timeunit 1ns;
	timeprecision 1ps;

	logic sdaDrv;

	// ----------------------------------------------------------------
	// line resolution
	// ----------------------------------------------------------------
	// pull-up: released line reads high, any party may pull it low
	assign sdaLine = sdaDrv & ~sdaOe;

	initial begin
		sclLine = 1'h1;
		sdaDrv  = 1'h1;
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// 10 clk a phase: well past the pin filter delay on both lines
	task automatic hold();
		repeat (10) @(posedge clk);
	endtask

	task automatic start();
		sdaDrv <= 1'h1;
		hold();
		sclLine <= 1'h1;
		hold();
		sdaDrv <= 1'h0;
		hold();
		sclLine <= 1'h0;
		hold();
	endtask

	task automatic stop();
		sdaDrv <= 1'h0;
		hold();
		sclLine <= 1'h1;
		hold();
		sdaDrv <= 1'h1;
		hold();
	endtask

	// data changes only while the clock is low
	task automatic sendBit(input logic b, output logic seen);
		sdaDrv <= b;
		hold();
		sclLine <= 1'h1;
		hold();
		seen = sdaLine;
		sclLine <= 1'h0;
		hold();
	endtask

	// eight bits then the ninth; writes pass last=1 to let the device answer
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sendBit(tx[i], rx[i]);
		end
		sendBit(last, ack);
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Testbench: channel setup and tracking registers reached over the two-wire port.
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin nErrors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import inductive_cfg_pkg::*;

	logic       clk;
	logic       rst_n;
	logic       sclLine;
	logic       sdaLine;
	logic       sdaOut;
	logic       sdaOe;
	logic       resRangeCh2;
	logic       resRangeCh3;
	logic [1:0] oscBandCh2;
	logic [1:0] oscBandCh3;
	logic [4:0] cycleCountCh2;
	logic [4:0] cycleCountCh3;
	logic [1:0] trackFactorCh0;
	logic [1:0] trackFactorCh1;
	logic [1:0] trackFactorCh2;
	logic [1:0] trackFactorCh3;
	int         nErrors;
	int         numChecks;

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	inductive_channel_config_regs u_inductive_channel_config_regs (
		.clk(clk), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.resRangeCh2(resRangeCh2), .oscBandCh2(oscBandCh2), .cycleCountCh2(cycleCountCh2),
		.resRangeCh3(resRangeCh3), .oscBandCh3(oscBandCh3), .cycleCountCh3(cycleCountCh3),
		.trackFactorCh0(trackFactorCh0), .trackFactorCh1(trackFactorCh1),
		.trackFactorCh2(trackFactorCh2), .trackFactorCh3(trackFactorCh3)
	);

	serial_host_model u_serial_host_model (
		.clk(clk), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic sendPtr(input logic [7:0] ptr);
		logic [7:0] rx;
		logic       ack;
		u_serial_host_model.start();
		u_serial_host_model.xfer({DEV_ADDR, 1'h0}, 1'h1, rx, ack);
		`CHK("address ack", 1'h0, ack)
		u_serial_host_model.xfer(ptr, 1'h1, rx, ack);
		`CHK("pointer ack", 1'h0, ack)
	endtask

	task automatic writeRegs(input logic [7:0] ptr, input logic [7:0] vals[$]);
		logic [7:0] rx;
		logic       ack;
		sendPtr(ptr);
		foreach (vals[i]) begin
			u_serial_host_model.xfer(vals[i], 1'h1, rx, ack);
			`CHK("data ack", 1'h0, ack)
		end
		u_serial_host_model.stop();
	endtask

	// repeated start keeps the pointer; last byte gets a master nack
	task automatic readRegs(input logic [7:0] ptr, input logic [7:0] exp[$]);
		logic [7:0] rx;
		logic       ack;
		sendPtr(ptr);
		u_serial_host_model.start();
		u_serial_host_model.xfer({DEV_ADDR, 1'h1}, 1'h1, rx, ack);
		`CHK("read address ack", 1'h0, ack)
		foreach (exp[i]) begin
			u_serial_host_model.xfer(8'hFF, 1'(i == exp.size() - 1), rx, ack);
			`CHK("read data", exp[i], rx)
		end
		u_serial_host_model.stop();
	endtask

	task automatic checkFields(input logic [7:0] s2, f0, s3, f12, f3);
		`CHK("resRangeCh2", s2[7], resRangeCh2)
		`CHK("oscBandCh2", s2[6:5], oscBandCh2)
		`CHK("cycleCountCh2", s2[4:0], cycleCountCh2)
		`CHK("resRangeCh3", s3[7], resRangeCh3)
		`CHK("oscBandCh3", s3[6:5], oscBandCh3)
		`CHK("cycleCountCh3", s3[4:0], cycleCountCh3)
		`CHK("trackFactorCh0", f0[2:1], trackFactorCh0)
		`CHK("trackFactorCh1", f12[5:4], trackFactorCh1)
		`CHK("trackFactorCh2", f12[7:6], trackFactorCh2)
		`CHK("trackFactorCh3", f3[1:0], trackFactorCh3)
		`CHK("sdaOut", 1'h0, sdaOut)
		`CHK("sdaOe", 1'h0, sdaOe)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testResetValues();
		checkFields(8'h04, 8'hDA, 8'h04, 8'h50, 8'h01);
		readRegs(8'h24, '{8'h04, 8'hDA, 8'h04, 8'h00, 8'h50, 8'h00, 8'h00, 8'h01});
	endtask

	// burst crosses unmapped offsets: those are acked, dropped and read as zero
	task automatic testBurst();
		writeRegs(8'h24, '{8'hA5, 8'hDE, 8'h5F, 8'h77, 8'h20, 8'h33, 8'h44, 8'h03});
		checkFields(8'hA5, 8'hDE, 8'h5F, 8'h20, 8'h03);
		readRegs(8'h24, '{8'hA5, 8'hDE, 8'h5F, 8'h00, 8'h20, 8'h00, 8'h00, 8'h03});
	endtask

	task automatic testWrongAddress();
		logic [7:0] rx;
		logic       ack;
		u_serial_host_model.start();
		u_serial_host_model.xfer({DEV_ADDR ^ 7'h01, 1'h0}, 1'h1, rx, ack);
		`CHK("foreign address ack", 1'h1, ack)
		u_serial_host_model.xfer(8'h24, 1'h1, rx, ack);
		u_serial_host_model.xfer(8'h00, 1'h1, rx, ack);
		`CHK("foreign data ack", 1'h1, ack)
		u_serial_host_model.stop();
		checkFields(8'hA5, 8'hDE, 8'h5F, 8'h20, 8'h03);
	endtask

	// every factor code on all channels, every legal band code on channel 3
	task automatic testFactorsAndBands();
		logic [1:0] f;
		logic [1:0] b;
		logic [7:0] s3;
		for (int i = 0; i < 4; i++) begin
			f = 2'(i);
			b = (i == 3) ? 2'h2 : 2'(i);
			s3 = {b[0], b, 3'h0, b};
			writeRegs(8'h25, '{{5'h1B, f, 1'h0}, s3, 8'h00, {f, ~f, 4'h0}, 8'h00, 8'h00, {6'h00, f}});
			checkFields(8'hA5, {5'h1B, f, 1'h0}, s3, {f, ~f, 4'h0}, {6'h00, f});
		end
	endtask

	task automatic testResetAgain();
		rst_n <= 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		checkFields(8'h04, 8'hDA, 8'h04, 8'h50, 8'h01);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		nErrors = 0;
		numChecks = 0;
		rst_n <= 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		testResetValues();
		testBurst();
		testWrongAddress();
		testFactorsAndBands();
		testResetAgain();
		stop_test();
	end

	initial begin
		repeat (90000) @(posedge clk);
		nErrors++;
		$display("[FAIL] run length expected below 90000 cycles seen limit reached");
		stop_test();
	end
endmodule
